//--- rtl/lag_chan.sv
/*
  One output channel: delays line and frame syncs, shapes line pulse.
  Assumes sync inputs are one-cycle pulses on clk_i.
*/
`default_nettype none
module lag_chan
  import sync_lag_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  lag_chan_if.chan  ch
);
  tmr_t              st_l_q;
  tmr_t              st_f_q;
  logic [CNT_W-1:0]  cnt_l_q;
  logic [CNT_W-1:0]  cnt_f_q;
  logic [LEN_W-1:0]  len_l_q;
  logic [LEN_W-1:0]  wcnt_q;
  logic              hs_q;
  logic              vs_q;
  logic              fire_l;
  logic              fire_f;
  logic              acc_l;
  logic              acc_f;

  assign acc_l  = ch.en && st_l_q == T_IDLE && ch.line_in;
  assign acc_f  = ch.en && st_f_q == T_IDLE && ch.frame_in;
  assign fire_l = st_l_q == T_RUN && cnt_l_q == '0;
  assign fire_f = st_f_q == T_RUN && cnt_f_q == '0;

  // Line lag timer, settings latched at the sync
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ch.en)
    begin
      st_l_q  <= T_IDLE;
      cnt_l_q <= '0;
      len_l_q <= '0;
    end
    else if (acc_l)
    begin
      st_l_q  <= T_RUN;
      cnt_l_q <= CNT_W'(ch.lag) + CNT_W'(PIPE_LAT - 1); // [RQ1] [RQ2] [RQ9]
      len_l_q <= ch.len; // [RQ9]
    end
    else if (st_l_q == T_RUN)
    begin
      if (fire_l)
        st_l_q <= T_IDLE;
      else
        cnt_l_q <= cnt_l_q - 1'b1;
    end
  end

  // Line pulse width
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ch.en)
    begin
      hs_q   <= 1'b0;
      wcnt_q <= '0;
    end
    else if (fire_l)
    begin
      hs_q   <= len_l_q != '0; // [RQ7]
      wcnt_q <= len_l_q - 1'b1;
    end
    else if (hs_q)
    begin
      if (wcnt_q == '0)
        hs_q <= 1'b0;
      else
        wcnt_q <= wcnt_q - 1'b1;
    end
  end

  // Frame lag timer
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ch.en)
    begin
      st_f_q  <= T_IDLE;
      cnt_f_q <= '0;
      vs_q    <= 1'b0;
    end
    else
    begin
      vs_q <= fire_f; // [RQ1]
      if (acc_f)
      begin
        st_f_q  <= T_RUN;
        cnt_f_q <= CNT_W'(ch.lag) + CNT_W'(PIPE_LAT - 1); // [RQ1] [RQ2]
      end
      else if (fire_f)
        st_f_q <= T_IDLE;
      else if (st_f_q == T_RUN)
        cnt_f_q <= cnt_f_q - 1'b1;
    end
  end

  assign ch.line_out   = hs_q;
  assign ch.frame_out  = vs_q;
  assign ch.line_busy  = st_l_q == T_RUN;
  assign ch.frame_busy = st_f_q == T_RUN;

  // Helper counters for checks
  logic [CNT_W-1:0] since_q;
  logic [LAG_W-1:0] lag_q;
  logic [LEN_W:0]   hi_q;
  logic [LEN_W-1:0] wid_q;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      since_q <= '0;
      lag_q   <= '0;
      hi_q    <= '0;
      wid_q   <= '0;
    end
    else
    begin
      since_q <= acc_l ? '0 : since_q + 1'b1;
      lag_q   <= acc_l ? ch.lag : lag_q;
      hi_q    <= hs_q ? hi_q + 1'b1 : '0;
      wid_q   <= fire_l ? len_l_q : wid_q;
    end
  end

  sequence s_hold_off;
    ##1 (!fire_l) [*8];
  endsequence

  a_line_lag_exact: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
    $rose(hs_q) && ch.en |-> since_q == CNT_W'(lag_q) + CNT_W'(PIPE_LAT))
    else $error("line sync lag count wrong");
  a_pipe_extra: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ2]
    acc_l |-> s_hold_off)
    else $error("line sync left before pipeline latency");
  a_pulse_len: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
    $fell(hs_q) && ch.en |-> hi_q == (LEN_W + 1)'(wid_q))
    else $error("line pulse width wrong");
  a_no_clamp: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ9]
    acc_l && ch.lag < 12'h020 |=> cnt_l_q == CNT_W'($past(ch.lag)) + CNT_W'(PIPE_LAT - 1))
    else $error("small lag was altered");
endmodule : lag_chan
`default_nettype wire

//--- rtl/lag_chan_if.sv
/*
  Carrier between the register block and one output channel timer.
  Assumes both ends share clk_i.
*/
`default_nettype none
interface lag_chan_if;
  logic [11:0] lag;
  logic [9:0]  len;
  logic        en;
  logic        line_in;
  logic        frame_in;
  logic        line_out;
  logic        frame_out;
  logic        line_busy;
  logic        frame_busy;

  modport ctl  (output lag, len, en, line_in, frame_in,
                input  line_out, frame_out, line_busy, frame_busy);
  modport chan (input  lag, len, en, line_in, frame_in,
                output line_out, frame_out, line_busy, frame_busy);
endinterface : lag_chan_if
`default_nettype wire

//--- rtl/lvds_sync_delay_and_line_pulse.sv
/*
  Top: Wishbone register slave, mode routing and two channel timers.
  Assumes sync inputs are one-cycle pulses from logic on clk_i.
*/
// The Wishbone slave port was chosen for this implementation.
`default_nettype none
// Summary of operation
// [RQ1] Each line and frame sync is held back by the programmed count; code drops a sync that arrives while its timer still runs.
// [RQ2] A fixed pipeline latency of ten clocks is added to that count.
// [RQ3] Software must program every lag to at least 32 clocks.
// [RQ4] Lag is twelve bits: low byte register plus four bits above.
// [RQ5] Channel A settings drive A alone, or both in dual modes 00/01/11.
// [RQ6] Channel B lag used only with dual output and mode 10.
// [RQ7] Line pulse lasts a ten-bit count: low byte plus two bits.
// [RQ8] Channel B width applies on output B only in mode 10.
// [RQ9] Values are used unclamped and taken up at the next sync.
module lvds_sync_delay_and_line_pulse
  import sync_lag_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [8:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        a_line_sync_i,
  input  wire logic        a_frame_sync_i,
  input  wire logic        b_line_sync_i,
  input  wire logic        b_frame_sync_i,
  output logic             out_a_line_o,
  output logic             out_a_frame_o,
  output logic             out_b_line_o,
  output logic             out_b_frame_o
);
  logic [7:0]        a_lag_lo_q;
  logic [3:0]        a_lag_hi_q;
  logic [7:0]        b_lag_lo_q;
  logic [3:0]        b_lag_hi_q;
  logic [7:0]        a_len_lo_q;
  logic [1:0]        a_len_hi_q;
  logic [7:0]        b_len_lo_q;
  logic [1:0]        b_len_hi_q;
  logic [1:0]        mode_q;
  logic              single_q;
  logic              ack_q;
  logic [31:0]       dat_q;
  logic [31:0]       rd_d;
  logic              req;
  logic              wr;
  logic [IDX_W-1:0]  idx;
  logic              two_stream;
  logic              b_mode;
  logic [LAG_W-1:0]  a_lag;
  logic [LAG_W-1:0]  b_lag;
  logic [LEN_W-1:0]  a_len;
  logic [LEN_W-1:0]  b_len;

  lag_chan_if ca ();
  lag_chan_if cb ();

  // Bus decode
  assign idx = wb_adr_i[8:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr  = req && wb_we_i && wb_sel_i[0];

  // Ack one cycle after request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_q <= 1'b0;
    else
      ack_q <= req;
  end

  // Timing registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      a_lag_lo_q <= REG_RST;
      a_lag_hi_q <= REG_RST[3:0];
      b_lag_lo_q <= REG_RST;
      b_lag_hi_q <= REG_RST[3:0];
      a_len_lo_q <= REG_RST;
      a_len_hi_q <= REG_RST[1:0];
      b_len_lo_q <= REG_RST;
      b_len_hi_q <= REG_RST[1:0];
    end
    else if (wr)
    begin
      unique case (idx)
        IDX_A_LAG_LO:
          a_lag_lo_q <= wb_dat_i[7:0];
        IDX_A_LAG_HI:
          a_lag_hi_q <= wb_dat_i[3:0]; // [RQ4]
        IDX_B_LAG_LO:
          b_lag_lo_q <= wb_dat_i[7:0];
        IDX_B_LAG_HI:
          b_lag_hi_q <= wb_dat_i[3:0]; // [RQ4]
        IDX_A_LEN_LO:
          a_len_lo_q <= wb_dat_i[7:0];
        IDX_A_LEN_HI:
          a_len_hi_q <= wb_dat_i[1:0]; // [RQ7]
        IDX_B_LEN_LO:
          b_len_lo_q <= wb_dat_i[7:0];
        IDX_B_LEN_HI:
          b_len_hi_q <= wb_dat_i[1:0]; // [RQ7]
        default:
        begin
        end
      endcase
    end
  end

  // Mode registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_q   <= MODE_RST;
      single_q <= OUTSEL_RST;
    end
    else if (wr)
    begin
      if (idx == IDX_MODE)
        mode_q <= wb_dat_i[MODE_LSB +: 2];
      if (idx == IDX_OUTSEL)
        single_q <= wb_dat_i[OUTSEL_BIT];
    end
  end

  // Read mux
  always_comb
  begin
    rd_d = '0;
    unique case (idx)
      IDX_MODE:
        rd_d[MODE_LSB +: 2] = mode_q;
      IDX_OUTSEL:
        rd_d[OUTSEL_BIT] = single_q;
      IDX_A_LAG_LO:
        rd_d[7:0] = a_lag_lo_q;
      IDX_A_LAG_HI:
        rd_d[3:0] = a_lag_hi_q; // [RQ4]
      IDX_B_LAG_LO:
        rd_d[7:0] = b_lag_lo_q;
      IDX_B_LAG_HI:
        rd_d[3:0] = b_lag_hi_q; // [RQ4]
      IDX_A_LEN_LO:
        rd_d[7:0] = a_len_lo_q;
      IDX_A_LEN_HI:
        rd_d[1:0] = a_len_hi_q; // [RQ7]
      IDX_B_LEN_LO:
        rd_d[7:0] = b_len_lo_q;
      IDX_B_LEN_HI:
        rd_d[1:0] = b_len_hi_q; // [RQ7]
      IDX_STATUS:
        rd_d[5:0] = {cb.frame_busy, cb.line_busy,
                     ca.frame_busy, ca.line_busy,
                     cb.line_out, ca.line_out};
      default:
        rd_d = '0;
    endcase
  end

  // Read data register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_q <= '0;
    else if (req)
      dat_q <= wb_we_i ? '0 : rd_d;
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Assembled settings
  assign a_lag = {a_lag_hi_q, a_lag_lo_q}; // [RQ4]
  assign b_lag = {b_lag_hi_q, b_lag_lo_q}; // [RQ4]
  assign a_len = {a_len_hi_q, a_len_lo_q}; // [RQ7]
  assign b_len = {b_len_hi_q, b_len_lo_q}; // [RQ7]

  // Mode routing
  assign b_mode     = mode_q == MODE_TWO_STREAM;
  assign two_stream = !single_q && b_mode;

  assign ca.lag      = a_lag; // [RQ5]
  assign ca.len      = a_len; // [RQ5]
  assign ca.en       = 1'b1;
  assign ca.line_in  = a_line_sync_i;
  assign ca.frame_in = a_frame_sync_i;

  assign cb.lag      = two_stream ? b_lag : a_lag; // [RQ5] [RQ6]
  assign cb.len      = b_mode ? b_len : a_len; // [RQ8]
  assign cb.en       = !single_q; // [RQ5]
  assign cb.line_in  = two_stream ? b_line_sync_i : a_line_sync_i;
  assign cb.frame_in = two_stream ? b_frame_sync_i : a_frame_sync_i;

  lag_chan u_chan_a (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ch    (ca)
  );

  lag_chan u_chan_b (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ch    (cb)
  );

  assign out_a_line_o  = ca.line_out;
  assign out_a_frame_o = ca.frame_out;
  assign out_b_line_o  = cb.line_out;
  assign out_b_frame_o = cb.frame_out;

  // Checks
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_prompt: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");

  a_hi_read_mask: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
    req && !wb_we_i && idx == IDX_A_LAG_HI |=> wb_dat_o[31:4] == '0)
    else $error("lag high read shows bits above four");

  a_lag_store: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
    wr && idx == IDX_B_LAG_HI ##1 !wr [*2] |-> b_lag[11:8] == $past(wb_dat_i[3:0], 2))
    else $error("lag high write not held");

  a_lag_route_b: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ6]
    !single_q && mode_q == MODE_TWO_STREAM |-> cb.lag == {b_lag_hi_q, b_lag_lo_q})
    else $error("channel B lag not selected in two stream mode");

  a_dual_share: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
    !single_q && mode_q != MODE_TWO_STREAM |-> cb.lag == a_lag && cb.len == a_len)
    else $error("dual link does not share channel A settings");

  a_len_route_b: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ8]
    mode_q == MODE_TWO_STREAM |-> cb.len == {b_len_hi_q, b_len_lo_q})
    else $error("channel B width not selected in mode 10");

  a_single_b_quiet: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
    single_q && $past(single_q) |-> !out_b_line_o && !out_b_frame_o)
    else $error("output B active in single output mode");

  a_lag_lo_store: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ4]
    wr && idx == IDX_A_LAG_LO |=> a_lag_lo_q == $past(wb_dat_i[7:0]))
    else $error("lag low write did not land");

  a_len_hi_store: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ7]
    wr && idx == IDX_A_LEN_HI |=> a_len[9:8] == $past(wb_dat_i[1:0]))
    else $error("width high write did not land");

  a_write_data_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i |=> wb_dat_o == '0)
    else $error("write cycle returned nonzero data");

  a_single_b_idle: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ5]
    single_q && $past(single_q) |-> !cb.line_busy && !cb.frame_busy)
    else $error("channel B timer running in single output mode");

  a_frame_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // [RQ1]
    out_a_frame_o |=> !out_a_frame_o)
    else $error("frame sync on output A longer than one cycle");

endmodule : lvds_sync_delay_and_line_pulse
`default_nettype wire

//--- rtl/sync_lag_pkg.sv
/*
  Constants and types for the sync lag and line pulse block.
  Assumes one 125 MHz pixel clock and word-indexed registers.
*/
`default_nettype none
package sync_lag_pkg;

  localparam int unsigned CLK_HZ   = 125_000_000;
  localparam int unsigned PIPE_LAT = 10;
  localparam int unsigned LAG_W    = 12;
  localparam int unsigned LEN_W    = 10;
  localparam int unsigned CNT_W    = 13;
  localparam int unsigned IDX_W    = 7;
  localparam int unsigned LAG_HI_W = 4;
  localparam int unsigned LEN_HI_W = 2;

  localparam logic [IDX_W-1:0] IDX_MODE      = 7'h10;
  localparam logic [IDX_W-1:0] IDX_OUTSEL    = 7'h18;
  localparam logic [IDX_W-1:0] IDX_A_LAG_LO  = 7'h28;
  localparam logic [IDX_W-1:0] IDX_A_LAG_HI  = 7'h29;
  localparam logic [IDX_W-1:0] IDX_B_LAG_LO  = 7'h2A;
  localparam logic [IDX_W-1:0] IDX_B_LAG_HI  = 7'h2B;
  localparam logic [IDX_W-1:0] IDX_A_LEN_LO  = 7'h2C;
  localparam logic [IDX_W-1:0] IDX_A_LEN_HI  = 7'h2D;
  localparam logic [IDX_W-1:0] IDX_B_LEN_LO  = 7'h2E;
  localparam logic [IDX_W-1:0] IDX_B_LEN_HI  = 7'h2F;
  localparam logic [IDX_W-1:0] IDX_STATUS    = 7'h40;

  localparam int unsigned MODE_LSB   = 5;
  localparam int unsigned OUTSEL_BIT = 4;

  localparam logic [1:0] MODE_TWO_STREAM = 2'h2;
  localparam logic [7:0] REG_RST         = 8'h00;
  localparam logic [1:0] MODE_RST        = 2'h0;
  localparam logic       OUTSEL_RST      = 1'b0;

  typedef enum logic [0:0] {
    T_IDLE = 1'b0,
    T_RUN  = 1'b1
  } tmr_t;

endpackage : sync_lag_pkg
`default_nettype wire

//--- sim/sync_source.sv
/*
  Video host stand-in: registers request bits into sync pulses one clock later.
  Assumes it shares clk_i and rst_i with the block under test.
*/
`default_nettype none
module sync_source
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] req_i,
  output logic      [3:0] sync_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pulse one clock after each request bit
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      sync_o <= 4'h0;
    else
      sync_o <= req_i;
  end
endmodule : sync_source
`default_nettype wire

//--- sim/testbench.sv
/*
  Self-checking bench: Wishbone register setup, sync stimulus, scoreboard.
  Assumes the sync lag package and the design sources are compiled first.
*/
`default_nettype none
module testbench
  import sync_lag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {int k; int t; logic [31:0] v;} note_t;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [8:0]  adr   = 9'h000;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] dat   = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [3:0]  req   = 4'h0;
  logic [3:0]  prev  = 4'h0;
  wire  [3:0]  sync;
  wire  [3:0]  outs;
  int          cyc_n = 0;
  int          err_total = 0;
  int          n_checks = 0;
  int          st[4];
  note_t       q[$];

  always #4 clk_i = ~clk_i;

  sync_source i_sync_source (.clk_i, .rst_i, .req_i(req), .sync_o(sync));

  lvds_sync_delay_and_line_pulse i_lvds_sync_delay_and_line_pulse (
    .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .a_line_sync_i(sync[0]), .a_frame_sync_i(sync[1]), .b_line_sync_i(sync[2]),
    .b_frame_sync_i(sync[3]), .out_a_line_o(outs[0]), .out_a_frame_o(outs[1]),
    .out_b_line_o(outs[2]), .out_b_frame_o(outs[3]));

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  // Oldest note of this kind; none left means an unexpected result
  task automatic take(input int k, input int t, input logic [31:0] v);
    int i;
    for (i = 0; i < q.size(); i++)
      if (q[i].k == k)
        break;
    if (i == q.size())
      chk(k, 32'hFF);
    else
    begin
      chk(t, q[i].t);
      chk(v, q[i].v);
      q.delete(i);
    end
  endtask : take

  task automatic wb(input logic [6:0] idx, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= {idx, 2'h0};
    sel <= 4'hF;
    dat <= {24'h0, d};
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [6:0] idx, input logic [7:0] e);
    q.push_back('{4, 0, {24'h0, e}});
    wb(idx, 1'b0, 8'h00);
  endtask : rd

  task automatic setv(input logic [6:0] lo, input int v);
    wb(lo, 1'b1, v[7:0]);
    wb(lo + 7'h1, 1'b1, v[15:8]);
  endtask : setv

  task automatic note(input int k, input int t, input int w);
    if (w != 0)
      q.push_back('{k, t, w});
  endtask : note

  function automatic int rl();
    return 32 + int'($urandom % 4064);
  endfunction : rl

  function automatic int rw();
    return 1 + int'($urandom % 1023);
  endfunction : rw

  task automatic run(input logic os, input logic [1:0] md, input int la, input int wa,
                     input int lb, input int wbw, input logic [3:0] m);
    int          tb;
    int          lg;
    int          wd;
    logic [1:0]  s;
    wb(IDX_OUTSEL, 1'b1, {3'h0, os, 4'h0});
    wb(IDX_MODE, 1'b1, {1'b0, md, 5'h00});
    setv(IDX_A_LAG_LO, la);
    setv(IDX_B_LAG_LO, lb);
    setv(IDX_A_LEN_LO, wa);
    setv(IDX_B_LEN_LO, wbw);
    rd(IDX_A_LAG_HI, {4'h0, la[11:8]});
    @(posedge clk_i);
    req <= m;
    @(posedge clk_i);
    req <= 4'h0;
    @(posedge clk_i);
    tb = cyc_n + 1;
    note(0, tb + la + PIPE_LAT, m[0] ? wa : 0);
    note(1, tb + la + PIPE_LAT, int'(m[1]));
    s  = (md == MODE_TWO_STREAM) ? m[3:2] : m[1:0];
    lg = (md == MODE_TWO_STREAM) ? lb : la;
    wd = (md == MODE_TWO_STREAM) ? wbw : wa;
    if (!os)
    begin
      note(2, tb + lg + PIPE_LAT, s[0] ? wd : 0);
      note(3, tb + lg + PIPE_LAT, int'(s[1]));
    end
    rd(IDX_STATUS, {2'h0, os ? 2'h0 : s, m[1:0], 2'h0});
    rd(IDX_MODE, {1'b0, md, 5'h00});
    setv(IDX_A_LAG_LO, la + 1);
    while (q.size() != 0)
      @(posedge clk_i);
  endtask : run

  // Output watcher: rise time and high length of each output, read data
  always @(negedge clk_i)
  begin
    for (int k = 0; k < 4; k++)
    begin
      if (outs[k] === 1'b1 && prev[k] !== 1'b1)
        st[k] = cyc_n;
      if (outs[k] !== 1'b1 && prev[k] === 1'b1)
        take(k, st[k], cyc_n - st[k]);
    end
    prev = outs;
    if (ack === 1'b1 && we === 1'b0)
      take(4, 0, rdat);
  end

  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 60000)
    begin
      err_total++;
      report_and_stop();
    end
  end

  initial
  begin
    void'($urandom(32'hb18a8117));
    repeat (2)
      @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 40; i < 48; i++)
      rd(i[6:0], 8'h00);
    wb(7'h3F, 1'b1, 8'hFF);
    rd(7'h3F, 8'h00);
    run(1'b1, 2'h0, rl(), rw(), rl(), rw(), 4'hF);
    run(1'b1, 2'h0, 32, 1023, 40, 3, 4'h1);
    run(1'b1, 2'h0, 5, 1, 40, 3, 4'h3);
    run(1'b0, 2'h0, rl(), rw(), rl(), rw(), 4'hF);
    run(1'b0, 2'h1, rl(), rw(), rl(), rw(), 4'h3);
    run(1'b0, 2'h2, rl(), rw(), rl(), rw(), 4'hF);
    run(1'b0, 2'h2, 4095, rw(), 33, rw(), 4'hF);
    run(1'b0, 2'h3, rl(), rw(), rl(), rw(), 4'h3);
    chk(q.size(), 0);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
